// >>> src/adc_monitor_status_gpio_ctrl.v
// Monitor selection, fault status, GPIO and low-side switch control with an AXI4-Lite register slave.
//
// Functional notes
// - Codes 011/100 route analog/digital supply monitor.
// - Supply monitor: inputs disconnected, gain forced one.
// - Codes 101/110/111 enable 0.2/1/10 uA burnout.
// - Burnout: source into positive, sink from negative.
// - Eight-bit fault status readable at 01h.
// - Prepend enable sends status before each result.
// - Rail/reference flags latched per conversion.
// - Power-on flag bit 7, cleared writing 0.
// - Bit 6 shows start-up finished, ready.
// - Four rail flags at bits 5 to 2.
// - Rail monitor gated by enable, works bypassed.
// - Bit 0 below 0.3 V, bit 1 below third.
// - Reference detection enabled by field at 05h.
// - Reference flags update at done falling edge.
// - Function select at 11h picks GPIO per pin.
// - 10h: upper nibble direction, lower nibble data.
// - Input reads pin; output drives written data.
// - Switch control at 06h: 1 closes, 0 opens.
// - Sleep command opens the low-side switch.
// - After reset switch open, control bit default.
// - Code 010 routes temperature sensor, inputs off.
`include "adc_monitor_map.vh"

module adc_monitor_status_gpio_ctrl (
   // Clock and reset
   input  wire        ref_clk,
   input  wire        rst,
   // AXI4-Lite slave
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Analog comparators and conversion engine
   input  wire        conversionDoneN,
   input  wire        posOutHigh,
   input  wire        posOutLow,
   input  wire        negOutHigh,
   input  wire        negOutLow,
   input  wire        refBelowLow,
   input  wire        refBelowThird,
   input  wire        powerOnEvent,
   input  wire        sleepCommandIn,
   // Analog routing controls
   output reg         analogSupplyMonSel,
   output reg         digitalSupplyMonSel,
   output reg         tempSensorSel,
   output reg         inputsDisconnect,
   output reg         forceUnityGain,
   output reg  [2:0]  burnoutEnable,
   output reg         burnoutSourcePos,
   output reg         burnoutSinkNeg,
   output reg         railMonitorOn,
   output reg  [1:0]  refMonitorOn,
   output reg         statusPrepend,
   output reg  [7:0]  statusByte,
   output reg         lowSideSwitchClosed,
   // GPIO pins
   input  wire [3:0]  gpioIn,
   output reg  [3:0]  gpioOut,
   output reg  [3:0]  gpioOutEnN,
   output reg  [3:0]  gpioFunctionSelect
);

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   reg [7:0] refCtrl;
   reg [7:0] excCtrl;
   reg [7:0] sysCtrl;
   reg [7:0] ioDirData;
   reg [7:0] ioFunction;
   reg [7:0] faultFlags;
   reg [7:0] startupCount;
   reg       doneDelay;
   reg [7:0] awAddr;
   reg [31:0] wData;
   reg [3:0] wStrb;
   reg       awHeld;
   reg       wHeld;

   wire [2:0] monitorSelect = sysCtrl[2:0];
   wire       doneFall      = doneDelay & ~conversionDoneN;
   wire       ready         = (startupCount == 8'h00);
   wire       doWrite       = awHeld & wHeld & ~s_axi_bvalid;
   wire       wrLow         = doWrite & wStrb[0];
   wire [7:0] wrByte        = wData[7:0];

   // Decodes a byte address into a mapped flag.
   function mapped;
      input [7:0] a;
      begin
         mapped = (a == `ADDR_FAULT_FLAGS) || (a == `ADDR_REF_CTRL) || (a == `ADDR_EXC_CTRL) ||
                  (a == `ADDR_SYS_CTRL) || (a == `ADDR_IO_DIR_DATA) || (a == `ADDR_IO_FUNCTION) ||
                  (a == `ADDR_CMD);
      end
   endfunction

   // Data nibble seen on read: pin level for inputs, written value for outputs.
   wire [3:0] dataView;
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : pinView
         assign dataView[gi] = ioDirData[4 + gi] ? gpioIn[gi] : ioDirData[gi];
      end
   endgenerate

   // ----------------------------------------------------------------
   // Write channel
   // ----------------------------------------------------------------
   // Address and data are held separately so either may arrive first.
   always @(posedge ref_clk) begin
      if (rst) begin
         awHeld        <= 1'b0;
         wHeld         <= 1'b0;
         awAddr        <= 8'h00;
         wData         <= 32'h0000_0000;
         wStrb         <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
      end else begin
         s_axi_awready <= ~awHeld & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready  <= ~wHeld & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid & s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
         if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(awAddr) ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            awHeld       <= 1'b0;
            wHeld        <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   always @(posedge ref_clk) begin
      if (rst) begin
         refCtrl    <= `RST_REF_CTRL;
         excCtrl    <= `RST_EXC_CTRL;
         sysCtrl    <= `RST_SYS_CTRL;
         ioDirData  <= `RST_IO_DIR_DATA;
         ioFunction <= `RST_IO_FUNCTION;
      end else begin
         if (wrLow && awAddr == `ADDR_REF_CTRL)
            refCtrl <= wrByte;
         if (wrLow && awAddr == `ADDR_EXC_CTRL)
            excCtrl <= wrByte;
         if (wrLow && awAddr == `ADDR_SYS_CTRL)
            sysCtrl <= wrByte;
         if (wrLow && awAddr == `ADDR_IO_DIR_DATA)
            ioDirData <= wrByte;
         if (wrLow && awAddr == `ADDR_IO_FUNCTION)
            ioFunction <= wrByte;
         // Sleep wins over a switch write in the same cycle, so the bridge always powers down.
         if (sleepCommandIn || (wrLow && awAddr == `ADDR_CMD && wrByte[`BIT_CMD_SLEEP]))
            excCtrl[`BIT_LOW_SWITCH] <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Fault status
   // ----------------------------------------------------------------
   // The power-on flag is set by the reset itself; a power-on event arriving with a clear wins.
   always @(posedge ref_clk) begin
      if (rst) begin
         faultFlags   <= 8'h80;
         startupCount <= `STARTUP_CYCLES;
         doneDelay    <= 1'b1;
      end else begin
         doneDelay   <= conversionDoneN;
         if (startupCount != 8'h00)
            startupCount <= startupCount - 8'h01;
         if (wrLow && awAddr == `ADDR_FAULT_FLAGS && !wrByte[`BIT_POWER_ON])
            faultFlags[`BIT_POWER_ON] <= 1'b0;
         if (powerOnEvent)
            faultFlags[`BIT_POWER_ON] <= 1'b1;
         faultFlags[`BIT_READY] <= ready;
         if (doneFall) begin
            // Flags show the last conversion only, not an accumulation.
            faultFlags[`BIT_POS_HIGH] <= excCtrl[`BIT_RAIL_MON_EN] & posOutHigh;
            faultFlags[`BIT_POS_LOW]  <= excCtrl[`BIT_RAIL_MON_EN] & posOutLow;
            faultFlags[`BIT_NEG_HIGH] <= excCtrl[`BIT_RAIL_MON_EN] & negOutHigh;
            faultFlags[`BIT_NEG_LOW]  <= excCtrl[`BIT_RAIL_MON_EN] & negOutLow;
            faultFlags[`BIT_REF_LOW]  <= (refCtrl[7:6] != 2'b00) & refBelowLow;
            faultFlags[`BIT_REF_THIRD] <= (refCtrl[7:6] != 2'b00) & refBelowThird;
         end
      end
   end

   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------
   always @(posedge ref_clk) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
            case (s_axi_araddr)
               `ADDR_FAULT_FLAGS: s_axi_rdata <= {24'h000000, faultFlags};
               `ADDR_REF_CTRL:    s_axi_rdata <= {24'h000000, refCtrl};
               `ADDR_EXC_CTRL:    s_axi_rdata <= {24'h000000, excCtrl};
               `ADDR_SYS_CTRL:    s_axi_rdata <= {24'h000000, sysCtrl};
               `ADDR_IO_DIR_DATA: s_axi_rdata <= {24'h000000, ioDirData[7:4], dataView};
               `ADDR_IO_FUNCTION: s_axi_rdata <= {24'h000000, ioFunction};
               default:           s_axi_rdata <= 32'h0000_0000;
            endcase
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Analog routing and pin outputs
   // ----------------------------------------------------------------
   always @(posedge ref_clk) begin
      if (rst) begin
         analogSupplyMonSel  <= 1'b0;
         digitalSupplyMonSel <= 1'b0;
         tempSensorSel       <= 1'b0;
         inputsDisconnect    <= 1'b0;
         forceUnityGain      <= 1'b0;
         burnoutEnable       <= 3'h0;
         burnoutSourcePos    <= 1'b0;
         burnoutSinkNeg      <= 1'b0;
         railMonitorOn       <= 1'b0;
         refMonitorOn        <= 2'h0;
         statusPrepend       <= 1'b0;
         statusByte          <= 8'h00;
         lowSideSwitchClosed <= 1'b0;
         gpioOut             <= 4'h0;
         gpioOutEnN          <= 4'hF;
         gpioFunctionSelect  <= 4'h0;
      end else begin
         analogSupplyMonSel  <= (monitorSelect == `MON_ANALOG_SUPPLY);
         digitalSupplyMonSel <= (monitorSelect == `MON_DIGITAL_SUPPLY);
         tempSensorSel       <= (monitorSelect == `MON_TEMP);
         inputsDisconnect    <= (monitorSelect == `MON_TEMP) || (monitorSelect == `MON_ANALOG_SUPPLY) ||
                                (monitorSelect == `MON_DIGITAL_SUPPLY);
         forceUnityGain      <= (monitorSelect == `MON_ANALOG_SUPPLY) ||
                                (monitorSelect == `MON_DIGITAL_SUPPLY);
         burnoutEnable       <= {monitorSelect == `MON_BURNOUT_10, monitorSelect == `MON_BURNOUT_1,
                                 monitorSelect == `MON_BURNOUT_0P2};
         burnoutSourcePos    <= monitorSelect[2] & (monitorSelect[1:0] != 2'b00);
         burnoutSinkNeg      <= monitorSelect[2] & (monitorSelect[1:0] != 2'b00);
         railMonitorOn       <= excCtrl[`BIT_RAIL_MON_EN];
         refMonitorOn        <= refCtrl[7:6];
         statusPrepend       <= sysCtrl[`BIT_STATUS_PREPEND];
         statusByte          <= faultFlags;
         lowSideSwitchClosed <= excCtrl[`BIT_LOW_SWITCH];
         gpioFunctionSelect  <= ioFunction[3:0];
         gpioOut             <= ioDirData[3:0];
         gpioOutEnN          <= ~(ioFunction[3:0] & ~ioDirData[7:4]);
      end
   end

endmodule

// >>> src/adc_monitor_map.vh
// Register offsets, field positions, codes and reset values of the monitor and status block.
`ifndef ADC_MONITOR_MAP_VH
`define ADC_MONITOR_MAP_VH

// ----------------------------------------------------------------
// Register byte addresses (index times four)
// ----------------------------------------------------------------
`define IDX_FAULT_FLAGS     8'h01
`define IDX_REF_CTRL        8'h05
`define IDX_EXC_CTRL        8'h06
`define IDX_SYS_CTRL        8'h09
`define IDX_IO_DIR_DATA     8'h10
`define IDX_IO_FUNCTION     8'h11
`define IDX_CMD             8'h20
`define ADDR_FAULT_FLAGS    8'h04
`define ADDR_REF_CTRL       8'h14
`define ADDR_EXC_CTRL       8'h18
`define ADDR_SYS_CTRL       8'h24
`define ADDR_IO_DIR_DATA    8'h40
`define ADDR_IO_FUNCTION    8'h44
`define ADDR_CMD            8'h80

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_POWER_ON        7
`define BIT_READY           6
`define BIT_POS_HIGH        5
`define BIT_POS_LOW         4
`define BIT_NEG_HIGH        3
`define BIT_NEG_LOW         2
`define BIT_REF_THIRD       1
`define BIT_REF_LOW         0
`define BIT_LOW_SWITCH      7
`define BIT_RAIL_MON_EN     3
`define BIT_STATUS_PREPEND  3
`define BIT_CMD_SLEEP       0

// ----------------------------------------------------------------
// Monitor select codes
// ----------------------------------------------------------------
`define MON_TEMP            3'h2
`define MON_ANALOG_SUPPLY   3'h3
`define MON_DIGITAL_SUPPLY  3'h4
`define MON_BURNOUT_0P2     3'h5
`define MON_BURNOUT_1       3'h6
`define MON_BURNOUT_10      3'h7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_REF_CTRL        8'h00
`define RST_EXC_CTRL        8'h00
`define RST_SYS_CTRL        8'h10
`define RST_IO_DIR_DATA     8'h00
`define RST_IO_FUNCTION     8'h00
`define STARTUP_CYCLES      8'h10

// ----------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// >>> verif/adc_monitor_sva.sv
// Concurrent checks on the ports of the monitor, status and GPIO register bank.
module adc_monitor_sva (
   // Clock, reset and read channel
   input wire logic       ref_clk,
   input wire logic       rst,
   input wire logic       s_axi_arvalid,
   input wire logic       s_axi_arready,
   input wire logic       s_axi_rvalid,
   // Block pins
   input wire logic       conversionDoneN,
   input wire logic       sleepCommandIn,
   input wire logic       analogSupplyMonSel,
   input wire logic       digitalSupplyMonSel,
   input wire logic       tempSensorSel,
   input wire logic       inputsDisconnect,
   input wire logic       forceUnityGain,
   input wire logic [2:0] burnoutEnable,
   input wire logic       burnoutSourcePos,
   input wire logic       burnoutSinkNeg,
   input wire logic [7:0] statusByte,
   input wire logic       lowSideSwitchClosed,
   input wire logic [3:0] gpioOutEnN,
   input wire logic [3:0] gpioFunctionSelect
);
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   logic       doneLast;
   logic [2:0] sinceFall;
   // Flags may move only shortly after a conversion ends, so the age of the last end is kept.
   always @(posedge ref_clk) begin
      doneLast <= conversionDoneN;
      if (rst)
         sinceFall <= 3'h7;
      else if (doneLast && !conversionDoneN)
         sinceFall <= 3'h0;
      else if (sinceFall != 3'h7)
         sinceFall <= sinceFall + 3'h1;
   end
   sequence s_booting;
      !statusByte[6] [*8];
   endsequence
   a_supply_route: assert property (
      (analogSupplyMonSel || digitalSupplyMonSel) |-> inputsDisconnect && forceUnityGain &&
      !(analogSupplyMonSel && digitalSupplyMonSel) && burnoutEnable == 3'h0) else $error("supply routing wrong");
   a_burnout_pair: assert property (
      (burnoutEnable != 3'h0 || burnoutSourcePos || burnoutSinkNeg) |->
      $onehot(burnoutEnable) && burnoutSourcePos && burnoutSinkNeg) else $error("burnout sources unpaired");
   a_temp_route: assert property (
      tempSensorSel |-> inputsDisconnect && !analogSupplyMonSel && !digitalSupplyMonSel && burnoutEnable == 3'h0)
      else $error("temperature routing wrong");
   a_por_flag: assert property ($fell(rst) |-> ##[1:2] statusByte[7]) else $error("power-on flag missing");
   a_ready_boot: assert property ($fell(rst) |-> s_booting ##[1:30] statusByte[6]) else $error("ready flag late");
   a_flag_latch: assert property (!$stable(statusByte[5:0]) |-> sinceFall < 3'h6) else $error("flags moved");
   a_sleep_open: assert property (sleepCommandIn |-> ##[1:2] !lowSideSwitchClosed) else $error("sleep kept switch");
   a_reset_open: assert property (
      $fell(rst) |-> !lowSideSwitchClosed ##1 !lowSideSwitchClosed) else $error("switch closed after reset");
   a_gpio_enable: assert property (
      (~gpioFunctionSelect & ~$past(gpioFunctionSelect) & ~gpioOutEnN) == 4'h0) else $error("analog pin driven");
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid) else $error("read answer missing");
endmodule

bind adc_monitor_status_gpio_ctrl adc_monitor_sva chk_u (.*);

// >>> verif/host_axi.sv
// Host controller model: AXI4-Lite master issuing register accesses.
module host_axi (
   // Clock
   input  wire logic        ref_clk,
   // Write channels
   output logic      [7:0]  s_axi_awaddr,
   output logic             s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output logic      [31:0] s_axi_wdata,
   output logic      [3:0]  s_axi_wstrb,
   output logic             s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   output logic             s_axi_bready,
   // Read channels
   output logic      [7:0]  s_axi_araddr,
   output logic             s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   output logic             s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
   end
   // Each task starts one edge later, so a strobe never changes twice in one time step.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r, output logic ok);
      ok = 1'b0;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int n = 0; n < 64 && !ok; n++) begin
         @(posedge ref_clk);
         if (s_axi_awready === 1'b1)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) begin
            r = s_axi_bresp;
            ok = 1'b1;
            s_axi_bready <= 1'b0;
         end
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r, output logic ok);
      ok = 1'b0;
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int n = 0; n < 64 && !ok; n++) begin
         @(posedge ref_clk);
         if (s_axi_arready === 1'b1)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            ok = 1'b1;
            s_axi_rready <= 1'b0;
         end
      end
   endtask
endmodule

// >>> verif/test_adc_monitor_status_gpio_ctrl.sv
// Self-checking bench for the monitor, status and GPIO register bank.
`include "adc_monitor_map.vh"
module test_adc_monitor_status_gpio_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, statusByte;
   logic [31:0] s_axi_wdata, s_axi_rdata, got, e, v;
   logic [31:0] seed = 32'h0000FF55;
   logic [3:0]  s_axi_wstrb, gpioOut, gpioOutEnN, gpioFunctionSelect;
   logic [3:0]  gpioIn = 4'h0;
   logic [2:0]  burnoutEnable;
   logic [1:0]  s_axi_bresp, s_axi_rresp, refMonitorOn, resp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, ok;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, statusPrepend, lowSideSwitchClosed;
   logic        analogSupplyMonSel, digitalSupplyMonSel, tempSensorSel, inputsDisconnect, forceUnityGain;
   logic        burnoutSourcePos, burnoutSinkNeg, railMonitorOn;
   logic        conversionDoneN = 1'b1;
   logic        posOutHigh = 1'b0, posOutLow = 1'b0, negOutHigh = 1'b0, negOutLow = 1'b0;
   logic        refBelowLow = 1'b0, refBelowThird = 1'b0, powerOnEvent = 1'b0, sleepCommandIn = 1'b0;
   int          n_mismatch = 0;
   int          cmp_count = 0;
   int          mdl[int];
   initial forever #12.5 ref_clk = ~ref_clk;
   adc_monitor_status_gpio_ctrl dut_u (.*);
   host_axi host_u (.*);
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic results();
      $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      cmp_count++;
      if (g !== x) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic bus_end(input logic [7:0] a);
      if (ok !== 1'b1) begin
         n_mismatch++;
         results();
      end
      chk(resp, (mdl.exists(a) || a == `ADDR_FAULT_FLAGS || a == `ADDR_CMD) ? `RESP_OKAY : `RESP_SLVERR);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host_u.wr(a, d, resp, ok);
      bus_end(a);
      if (mdl.exists(a))
         mdl[a] = d[7:0];
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
      host_u.rd(a, got, resp, ok);
      bus_end(a);
      chk(got & m, x & m);
   endtask
   // The model is cleared with the design, and the wait lets the start-up count finish.
   task automatic doreset();
      rst <= 1'b1;
      tick(16);
      rst <= 1'b0;
      mdl = '{`ADDR_REF_CTRL: `RST_REF_CTRL, `ADDR_EXC_CTRL: `RST_EXC_CTRL, `ADDR_SYS_CTRL: `RST_SYS_CTRL,
              `ADDR_IO_DIR_DATA: `RST_IO_DIR_DATA, `ADDR_IO_FUNCTION: `RST_IO_FUNCTION};
      tick(24);
      foreach (mdl[k]) rc(k[7:0], mdl[k], 32'hFFFFFFFF);
      rc(`ADDR_FAULT_FLAGS, 32'hC0, 32'hC0);
      chk(lowSideSwitchClosed, 1'b0);
   endtask
   initial begin
      tick(90000);
      n_mismatch++;
      results();
   end
   initial begin
      doreset();
      wr(`ADDR_FAULT_FLAGS, 32'h7F);
      rc(`ADDR_FAULT_FLAGS, 32'h40, 32'hC0);
      rc(8'h0C, 32'h0, 32'hFFFFFFFF);
      wr(8'h0C, rnd());
      $display("test reset and map done");
      for (int c = 0; c < 8; c++) begin
         wr(`ADDR_SYS_CTRL, {28'h0000001, c[0], c[2:0]});
         tick(3);
         got = {analogSupplyMonSel, digitalSupplyMonSel, tempSensorSel, inputsDisconnect, forceUnityGain,
                burnoutEnable, burnoutSourcePos, burnoutSinkNeg, statusPrepend};
         e = {c == 3, c == 4, c == 2, c inside {[2:4]}, c inside {[3:4]}, c == 7, c == 6, c == 5, c > 4, c > 4, c[0]};
         chk(got, e);
      end
      wr(`ADDR_SYS_CTRL, 32'h10);
      $display("test monitor select done");
      wr(`ADDR_EXC_CTRL, 32'h88);
      tick(3);
      chk({lowSideSwitchClosed, railMonitorOn}, 2'h3);
      sleepCommandIn <= 1'b1;
      tick(1);
      sleepCommandIn <= 1'b0;
      tick(3);
      chk(lowSideSwitchClosed, 1'b0);
      wr(`ADDR_EXC_CTRL, 32'h88);
      wr(`ADDR_CMD, 32'h01);
      tick(3);
      chk(lowSideSwitchClosed, 1'b0);
      mdl[`ADDR_EXC_CTRL] = 8'h08;
      rc(`ADDR_EXC_CTRL, mdl[`ADDR_EXC_CTRL], 32'hFF);
      $display("test low-side switch done");
      for (int i = 0; i < 6; i++) begin
         v = rnd();
         wr(`ADDR_EXC_CTRL, {v[1], 3'h0, v[0], 3'h0});
         wr(`ADDR_REF_CTRL, {v[2], v[3], 6'h00});
         {posOutHigh, posOutLow, negOutHigh, negOutLow, refBelowThird, refBelowLow} <= v[13:8];
         tick(2);
         conversionDoneN <= 1'b0;
         tick(2);
         conversionDoneN <= 1'b1;
         {posOutHigh, posOutLow, negOutHigh, negOutLow, refBelowThird, refBelowLow} <= ~v[13:8];
         tick(4);
         e = {2'h1, v[0] ? v[13:10] : 4'h0, (v[2] | v[3]) ? v[9:8] : 2'h0};
         rc(`ADDR_FAULT_FLAGS, e, 32'hFF);
         chk(statusByte, e[7:0]);
         chk(lowSideSwitchClosed, v[1]);
         chk(refMonitorOn, {v[2], v[3]});
      end
      powerOnEvent <= 1'b1;
      tick(1);
      powerOnEvent <= 1'b0;
      rc(`ADDR_FAULT_FLAGS, 32'h80, 32'h80);
      $display("test fault flags done");
      for (int i = 0; i < 4; i++) begin
         v = rnd();
         gpioIn <= v[11:8];
         wr(`ADDR_IO_FUNCTION, {4'h0, v[15:12]});
         wr(`ADDR_IO_DIR_DATA, v[7:0]);
         tick(4);
         chk({gpioFunctionSelect, gpioOutEnN, gpioOut}, {v[15:12], ~(v[15:12] & ~v[7:4]), v[3:0]});
         rc(`ADDR_IO_DIR_DATA, {v[7:4], v[7:4] & v[11:8] | ~v[7:4] & v[3:0]}, {4'hF, v[15:12]});
      end
      $display("test gpio done");
      wr(`ADDR_EXC_CTRL, 32'h80);
      tick(3);
      doreset();
      $display("test second reset done");
      results();
   end
endmodule
